/* inc/lsd_pkg.sv */
// Contract
// RULE1: Each segment pin goes to the display or to general I/O via per-pin mask bits.
// RULE2: Display disabled: segment pins go to ground only after the current even frame.
// RULE3: Blink scope selects one pixel, all pixels on segment 0, or all pixels.
// RULE4: Blink rate comes from a blink prescaler under a three-bit rate field.
// RULE5: Larger variants drive N segments by four commons or N-4 by eight.
// RULE6: Eight-common select routes top four segments or commons 4 to 7 to shared pins.
// RULE7: Enable switch closed while enabled; opens only at end of the even frame.
// RULE8: Without high drive, strong switch closes for pulse-length prescaled pulses per change.
// RULE9: High-drive bit set keeps the strong divider switch permanently closed.
// RULE10: New contrast level takes effect only at the start of a frame.
// RULE11: Supply select 0 picks the internal booster, 1 the external pin.
// RULE12: Zero to seven dead phases between frame pairs, all lines grounded.
// RULE13: Software clears the frame-start flag, waits for it, then rewrites memory.
// RULE14: Software should not refresh display memory faster than the frame rate.
// RULE15: Display keeps running in wait and active-halt, stops in halt.
// RULE16: Software keeps ultra-low-power bit zero when booster used in active-halt.
// RULE17: Blink scope codes: 00 off, 01 pixel, 10 segment 0, 11 all.
// RULE18: Blink rate codes 000 to 111 divide the LCD clock by 8 up to 1024.
// RULE19: Frame-start flag set at start of last phase of even frame; clear bit resets it.
// RULE20: Frames alternate odd and even, starting odd, commons inverted between them.
// RULE21: Interrupt request high only while frame-start flag and its enable are set.
// RULE22: A pin masked to general I/O is not driven by display logic.
`default_nettype none
package lsd_pkg;
    // =========================================================
    // Register indices (byte address is four times the index)
    localparam logic [5:0] LSD_IDX_CTRL1 = 6'h00;
    localparam logic [5:0] LSD_IDX_CTRL2 = 6'h01;
    localparam logic [5:0] LSD_IDX_CTRL3 = 6'h02;
    localparam logic [5:0] LSD_IDX_FRQ = 6'h03;
    localparam logic [5:0] LSD_IDX_MASK0 = 6'h04;
    localparam logic [5:0] LSD_IDX_MASK_LAST = 6'h09;
    localparam logic [5:0] LSD_IDX_CTRL4 = 6'h0a;
    localparam logic [5:0] LSD_IDX_RAM0 = 6'h10;
    localparam logic [5:0] LSD_IDX_RAM_LAST = 6'h1f;
    localparam logic [7:0] LSD_RESET_BYTE = 8'h00;
    // =========================================================
    // Field positions
    localparam int LSD_BLINK_MODE_LSB = 6;
    localparam int LSD_BLINK_RATE_LSB = 3;
    localparam int LSD_PULSE_LSB = 5;
    localparam int LSD_HOLD_BIT = 4;
    localparam int LSD_CONTRAST_LSB = 1;
    localparam int LSD_SUPPLY_BIT = 0;
    localparam int LSD_ENABLE_BIT = 6;
    localparam int LSD_IRQEN_BIT = 5;
    localparam int LSD_SOF_BIT = 4;
    localparam int LSD_FRAME_START_CLEAR_BIT = 3;
    localparam int LSD_DEAD_LSB = 0;
    localparam int LSD_PS_LSB = 4;
    localparam int LSD_DIV_LSB = 0;
    localparam int LSD_DUTY_LSB = 1;
    localparam int LSD_EIGHT_BIT = 0;
    // =========================================================
    // Timing constants
    localparam logic [4:0] LSD_DIV_BASE = 5'h10;
    localparam logic [3:0] LSD_BLINK_MIN_LOG2 = 4'h3;
    localparam logic [3:0] LSD_SHARED_PINS = 4'h4;
    // =========================================================
    // Modes and states
    typedef enum logic [1:0] {
        LSD_BLINK_OFF = 2'h0,
        LSD_BLINK_ONE = 2'h1,
        LSD_BLINK_SEG0 = 2'h2,
        LSD_BLINK_ALL = 2'h3
    } lsd_blink_e;
    typedef enum logic [2:0] {
        LSD_ST_IDLE = 3'h1,
        LSD_ST_RUN = 3'h2,
        LSD_ST_DEAD = 3'h4
    } lsd_state_e;
endpackage
`default_nettype wire

/* core/lsd_clk_prescale.sv */
`timescale 1ns/1ps
`default_nettype none
module lsd_clk_prescale
    import lsd_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Control
    input wire logic i_run,
    input wire logic [3:0] i_ps,
    input wire logic [3:0] i_div,
    // Ticks
    output logic o_ps_tick,
    output logic o_phase_tick
);
    logic [15:0] ps_cnt_q;
    logic [4:0] div_cnt_q;
    logic ps_hit;
    logic div_hit;

    assign ps_hit = ps_cnt_q == 16'((17'h1 << i_ps) - 17'h1);
    assign div_hit = div_cnt_q == 5'(LSD_DIV_BASE + 5'(i_div) - 5'h1);
    assign o_ps_tick = i_run && ps_hit;

    // =========================================================
    // Power-of-two prescaler, then divide by 16 to 31
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst || !i_run || ps_hit)
            ps_cnt_q <= 16'h0000;
        else
            ps_cnt_q <= ps_cnt_q + 16'h0001;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst || !i_run)
            div_cnt_q <= 5'h00;
        else if (ps_hit)
            div_cnt_q <= div_hit ? 5'h00 : div_cnt_q + 5'h01;
    end

    assign o_phase_tick = o_ps_tick && div_hit;
endmodule
`default_nettype wire

/* core/lsd_blink_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module lsd_blink_gen
    import lsd_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Control
    input wire logic i_lcd_tick,
    input wire logic [2:0] i_rate,
    // Blink phase, high while blinking pixels are dark
    output logic o_blink_dark
);
    logic [9:0] cnt_q;
    logic [3:0] log2;
    logic half_hit;

    // Period is 2^(rate+3) LCD clocks; the state toggles every half
    assign log2 = LSD_BLINK_MIN_LOG2 + 4'(i_rate); // RULE18
    assign half_hit = cnt_q == 10'((11'h1 << (log2 - 4'h1)) - 11'h1);

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
            cnt_q <= 10'h000;
        else if (i_lcd_tick)
            cnt_q <= half_hit ? 10'h000 : cnt_q + 10'h001; // RULE4
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
            o_blink_dark <= 1'b0;
        else if (i_lcd_tick && half_hit)
            o_blink_dark <= !o_blink_dark;
    end
endmodule
`default_nettype wire

/* core/lsd_core.sv */
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lsd_core
    import lsd_pkg::*;
#(
    parameter int N_SEG = 44
)
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Avalon-MM slave
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Power mode
    input wire logic i_halt_mode,
    // Panel drive
    output logic [7:0] o_backplane_active,
    output logic o_frame_even,
    output logic o_ground_all,
    output logic [N_SEG-1:0] o_front_pixel,
    output logic [N_SEG-1:0] o_front_drive_en,
    output logic o_shared_com_sel,
    output logic [3:0] o_shared_pin_data,
    // Analog control
    output logic o_en_switch,
    output logic o_hd_switch,
    output logic [2:0] o_contrast,
    output logic o_supply_external,
    // Events
    output logic o_sof,
    output logic o_irq
);
    // =========================================================
    // Elaboration check
    if (N_SEG != 44 && N_SEG != 40 && N_SEG != 28)
        $error("N_SEG must be 44, 40 or 28");

    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);

    function automatic logic [7:0] lsd_wr8(input logic [7:0] old, input logic [31:0] wd,
                                           input logic be);
        lsd_wr8 = be ? wd[7:0] : old;
    endfunction

    function automatic logic [3:0] lsd_ncom(input logic [1:0] duty, input logic eight);
        if (eight)
            lsd_ncom = 4'h8;
        else
            lsd_ncom = (duty == 2'h0) ? 4'h1 : 4'(duty) + 4'h1;
    endfunction

    // =========================================================
    // Register file
    logic [7:0] ctrl1_q, ctrl2_q, ctrl3_q, frq_q, ctrl4_q;
    logic [47:0] mask_q;
    logic [N_SEG-1:0] mem_q [8];
    logic sof_q;
    logic wait_q;
    logic acc_wr, acc_rd;
    logic [31:0] rd_d;
    logic sof_set;
    logic frame_start_clear_wr;
    logic [2:0] ram_com;
    logic ram_hi;

    assign acc_wr = i_avs_write && !wait_q;
    assign acc_rd = i_avs_read && !wait_q;
    assign ram_com = i_avs_address[3:1];
    assign ram_hi = i_avs_address[0];
    assign frame_start_clear_wr = acc_wr && i_avs_address == LSD_IDX_CTRL3 && i_avs_byteenable[0]
                     && i_avs_writedata[LSD_FRAME_START_CLEAR_BIT];

    // One wait cycle per request: the answer edge is the second one
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
            wait_q <= 1'b1;
        else if (i_avs_read || i_avs_write)
            wait_q <= !wait_q;
        else
            wait_q <= 1'b1;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            ctrl1_q <= LSD_RESET_BYTE;
            ctrl2_q <= LSD_RESET_BYTE;
            ctrl3_q <= LSD_RESET_BYTE;
            frq_q <= LSD_RESET_BYTE;
            ctrl4_q <= LSD_RESET_BYTE;
            mask_q <= '0;
        end
        else if (acc_wr)
        begin
            unique case (i_avs_address)
                LSD_IDX_CTRL1: ctrl1_q <= lsd_wr8(ctrl1_q, i_avs_writedata, i_avs_byteenable[0]);
                LSD_IDX_CTRL2: ctrl2_q <= lsd_wr8(ctrl2_q, i_avs_writedata, i_avs_byteenable[0]);
                // Flag and its self-clearing clear bit are not stored here
                LSD_IDX_CTRL3: ctrl3_q <= lsd_wr8(ctrl3_q, i_avs_writedata, i_avs_byteenable[0])
                                          & 8'h67;
                LSD_IDX_FRQ: frq_q <= lsd_wr8(frq_q, i_avs_writedata, i_avs_byteenable[0]);
                LSD_IDX_CTRL4: ctrl4_q <= lsd_wr8(ctrl4_q, i_avs_writedata, i_avs_byteenable[0])
                                          & 8'h01;
                default:
                    if (i_avs_address >= LSD_IDX_MASK0 && i_avs_address <= LSD_IDX_MASK_LAST)
                        mask_q[8*(i_avs_address-LSD_IDX_MASK0) +: 8] <= lsd_wr8( // RULE1
                            mask_q[8*(i_avs_address-LSD_IDX_MASK0) +: 8],
                            i_avs_writedata, i_avs_byteenable[0]);
            endcase
        end
    end

    // Display memory: two words per common, low word holds segments 0 to 31
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            for (int c = 0; c < 8; c++)
                mem_q[c] <= '0;
        end
        else if (acc_wr && i_avs_address >= LSD_IDX_RAM0 && i_avs_address <= LSD_IDX_RAM_LAST)
        begin
            for (int b = 0; b < N_SEG; b++)
                if ((b >= 32) == ram_hi && i_avs_byteenable[(b % 32) / 8])
                    mem_q[ram_com][b] <= i_avs_writedata[b % 32];
        end
    end

    always_comb
    begin
        rd_d = 32'h0000_0000;
        unique case (i_avs_address)
            LSD_IDX_CTRL1: rd_d[7:0] = ctrl1_q;
            LSD_IDX_CTRL2: rd_d[7:0] = ctrl2_q;
            LSD_IDX_CTRL3: rd_d[7:0] = ctrl3_q | (8'(sof_q) << LSD_SOF_BIT);
            LSD_IDX_FRQ: rd_d[7:0] = frq_q;
            LSD_IDX_CTRL4: rd_d[7:0] = ctrl4_q;
            default:
                if (i_avs_address >= LSD_IDX_MASK0 && i_avs_address <= LSD_IDX_MASK_LAST)
                    rd_d[7:0] = mask_q[8*(i_avs_address-LSD_IDX_MASK0) +: 8];
                else if (i_avs_address >= LSD_IDX_RAM0 && i_avs_address <= LSD_IDX_RAM_LAST)
                    for (int b = 0; b < N_SEG; b++)
                        if ((b >= 32) == ram_hi)
                            rd_d[b % 32] = mem_q[ram_com][b];
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
            o_avs_readdata <= 32'h0000_0000;
        else if (i_avs_read && wait_q)
            o_avs_readdata <= rd_d;
    end
    assign o_avs_waitrequest = wait_q;

    // =========================================================
    // Field views
    logic enable, eight, hold, halt_stop;
    logic [1:0] blink_mode;
    logic [2:0] pulse_len, dead_len;
    assign enable = ctrl3_q[LSD_ENABLE_BIT];
    assign eight = ctrl4_q[LSD_EIGHT_BIT];
    assign hold = ctrl2_q[LSD_HOLD_BIT];
    assign blink_mode = ctrl1_q[LSD_BLINK_MODE_LSB +: 2];
    assign pulse_len = ctrl2_q[LSD_PULSE_LSB +: 3];
    assign dead_len = ctrl3_q[LSD_DEAD_LSB +: 3];
    assign halt_stop = i_halt_mode; // RULE15

    // =========================================================
    // Clocking helpers
    logic ps_tick, phase_tick, blink_dark;
    lsd_state_e state_q, state_d;

    lsd_clk_prescale u_prescale (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_run(state_q != LSD_ST_IDLE || (enable && !halt_stop)),
        .i_ps(frq_q[LSD_PS_LSB +: 4]),
        .i_div(frq_q[LSD_DIV_LSB +: 4]),
        .o_ps_tick(ps_tick),
        .o_phase_tick(phase_tick)
    );

    lsd_blink_gen u_blink (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_lcd_tick(phase_tick),
        .i_rate(ctrl1_q[LSD_BLINK_RATE_LSB +: 3]),
        .o_blink_dark(blink_dark)
    );

    // =========================================================
    // Frame sequencer
    logic [2:0] phase_q, phase_d, dead_q, dead_d, last;
    logic even_q, even_d, frame_start;

    assign last = 3'(lsd_ncom(ctrl1_q[LSD_DUTY_LSB +: 2], eight) - 4'h1); // RULE5

    always_comb
    begin
        state_d = state_q;
        phase_d = phase_q;
        even_d = even_q;
        dead_d = dead_q;
        if (halt_stop)
            state_d = LSD_ST_IDLE;
        else
        begin
            unique case (state_q)
                LSD_ST_IDLE:
                    if (enable)
                    begin
                        state_d = LSD_ST_RUN;
                        phase_d = 3'h0;
                        even_d = 1'b0; // RULE20
                    end
                LSD_ST_RUN:
                    if (phase_tick)
                    begin
                        if (phase_q < last)
                            phase_d = phase_q + 3'h1;
                        else if (even_q && !enable)
                            state_d = LSD_ST_IDLE; // RULE2 RULE7
                        else if (even_q && dead_len != 3'h0)
                        begin
                            state_d = LSD_ST_DEAD; // RULE12
                            dead_d = dead_len;
                        end
                        else
                        begin
                            phase_d = 3'h0;
                            even_d = !even_q; // RULE20
                        end
                    end
                LSD_ST_DEAD:
                    if (phase_tick)
                    begin
                        dead_d = dead_q - 3'h1;
                        if (dead_q == 3'h1)
                        begin
                            state_d = enable ? LSD_ST_RUN : LSD_ST_IDLE;
                            phase_d = 3'h0;
                            even_d = 1'b0;
                        end
                    end
            endcase
        end
    end

    assign frame_start = state_d == LSD_ST_RUN && phase_d == 3'h0
                         && (state_q != LSD_ST_RUN || phase_q != 3'h0 || even_q != even_d);
    assign sof_set = state_d == LSD_ST_RUN && even_d && phase_d == last
                     && (state_q != LSD_ST_RUN || phase_q != phase_d || !even_q); // RULE19

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            state_q <= LSD_ST_IDLE;
            phase_q <= 3'h0;
            even_q <= 1'b0;
            dead_q <= 3'h0;
        end
        else
        begin
            state_q <= state_d;
            phase_q <= phase_d;
            even_q <= even_d;
            dead_q <= dead_d;
        end
    end

    // Set wins over a clear landing in the same cycle
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
            sof_q <= 1'b0;
        else if (sof_set)
            sof_q <= 1'b1; // RULE19
        else if (frame_start_clear_wr)
            sof_q <= 1'b0;
    end

    // =========================================================
    // Strong divider pulse, counted in prescaled clocks
    logic [2:0] pulse_q;
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
            pulse_q <= 3'h0;
        // A zero length cuts a running pulse short so the switch opens at once
        else if (pulse_len == 3'h0)
            pulse_q <= 3'h0; // RULE8
        else if (state_q != LSD_ST_IDLE && phase_tick)
            pulse_q <= pulse_len; // RULE8
        else if (ps_tick && pulse_q != 3'h0)
            pulse_q <= pulse_q - 3'h1;
    end

    // =========================================================
    // Pixel data with blink applied
    logic [N_SEG-1:0] pix;
    always_comb
    begin
        pix = mem_q[phase_q];
        if (blink_dark)
        begin
            unique case (lsd_blink_e'(blink_mode)) // RULE3 RULE17
                LSD_BLINK_OFF: pix = pix;
                LSD_BLINK_ONE: pix[0] = (phase_q == 3'h0) ? 1'b0 : pix[0];
                LSD_BLINK_SEG0: pix[0] = 1'b0;
                LSD_BLINK_ALL: pix = '0;
            endcase
        end
    end

    // =========================================================
    // Registered outputs
    logic [7:0] com_d;
    assign com_d = (state_q == LSD_ST_RUN) ? 8'(8'h01 << phase_q) : 8'h00;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            o_backplane_active <= 8'h00;
            o_frame_even <= 1'b0;
            o_ground_all <= 1'b1;
            o_front_pixel <= '0;
            o_front_drive_en <= '0;
            o_shared_com_sel <= 1'b0;
            o_shared_pin_data <= 4'h0;
        end
        else
        begin
            o_backplane_active <= com_d;
            o_frame_even <= even_q;
            o_ground_all <= state_q != LSD_ST_RUN; // RULE2 RULE12
            o_front_pixel <= pix & mask_q[N_SEG-1:0];
            o_front_drive_en <= mask_q[N_SEG-1:0]; // RULE22
            o_shared_com_sel <= eight; // RULE6
            if (eight)
            begin
                o_front_drive_en[N_SEG-1 -: 4] <= 4'h0;
                o_shared_pin_data <= com_d[7:4]; // RULE6
            end
            else
                o_shared_pin_data <= pix[N_SEG-1 -: 4] & mask_q[N_SEG-1 -: 4];
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            o_en_switch <= 1'b0;
            o_hd_switch <= 1'b0;
            o_contrast <= 3'h0;
            o_supply_external <= 1'b0;
            o_sof <= 1'b0;
            o_irq <= 1'b0;
        end
        else
        begin
            o_en_switch <= enable || state_q != LSD_ST_IDLE; // RULE7
            o_hd_switch <= hold || pulse_q != 3'h0; // RULE8 RULE9
            if (frame_start)
                o_contrast <= ctrl2_q[LSD_CONTRAST_LSB +: 3]; // RULE10
            o_supply_external <= ctrl2_q[LSD_SUPPLY_BIT]; // RULE11
            o_sof <= sof_q;
            o_irq <= sof_q && ctrl3_q[LSD_IRQEN_BIT]; // RULE21
        end
    end

    // =========================================================
    // Checks
    a_sof_position: assert property ($rose(sof_q) |-> state_q == LSD_ST_RUN && even_q // RULE19
        && phase_q == last) else $error("frame-start flag set at wrong phase");
    a_sof_clear: assert property (frame_start_clear_wr && !sof_set |=> !sof_q) // RULE19
        else $error("frame-start flag not cleared");
    a_hd_hold: assert property (hold |=> o_hd_switch) // RULE9
        else $error("strong switch open under high drive");
    a_hd_off: assert property ((!hold && pulse_len == 3'h0) [*8] |-> !o_hd_switch) // RULE8
        else $error("strong switch closed with zero pulse length");
    a_en_switch: assert property (enable |=> o_en_switch) // RULE7
        else $error("enable switch open while enabled");
    a_stop_even: assert property (state_q == LSD_ST_RUN && state_d == LSD_ST_IDLE && !halt_stop
        |-> even_q && phase_q == last) else $error("display stopped mid frame"); // RULE2
    a_dead_ground: assert property (state_q == LSD_ST_DEAD |=> o_ground_all // RULE12
        && o_backplane_active == 8'h00) else $error("lines not grounded in dead time");
    a_contrast_frame: assert property (!$stable(o_contrast) |-> $past(frame_start)) // RULE10
        else $error("contrast changed mid frame");
    a_irq_gate: assert property (o_irq == $past(sof_q && ctrl3_q[LSD_IRQEN_BIT])) // RULE21
        else $error("interrupt not gated by flag and enable");
    a_mask_release: assert property ((o_front_drive_en & ~$past(mask_q[N_SEG-1:0])) == '0)
        else $error("masked pin driven"); // RULE22
    a_odd_first: assert property (state_q == LSD_ST_IDLE && state_d == LSD_ST_RUN // RULE20
        |=> !even_q && phase_q == 3'h0) else $error("first frame not odd");
    a_wait_once: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low two cycles");
endmodule
`default_nettype wire

/* sim/lsd_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Passive glass: counts frame flips it sees
module lsd_panel_model
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Panel lines
    input wire logic i_frame_even,
    input wire logic i_ground_all,
    // Observation
    output logic [15:0] o_frames
);
    logic even_q;
    always_ff @(posedge i_core_clk)
    begin
        even_q <= i_frame_even;
        if (!i_nrst)
            o_frames <= 16'h0000;
        else if (!i_ground_all && even_q != i_frame_even)
            o_frames <= o_frames + 16'h0001;
    end
endmodule
`default_nettype wire

/* sim/test_lsd_core.sv */
`timescale 1ns/1ps
`default_nettype none
module test_lsd_core;
    import lsd_pkg::*;
    logic clk, nrst, rd, wr, halt;
    logic [5:0] adr;
    logic [31:0] wd, rdat, q;
    logic [3:0] be;
    logic [7:0] bpl, cur;
    logic even, gnd, shsel, ensw, hdsw, ext, sof, irq, wreq;
    logic [43:0] pix, den;
    logic [3:0] shd;
    logic [2:0] con;
    logic [15:0] frames, f0;
    int miscompares = 0;
    int num_checks = 0;
    lsd_core #(.N_SEG(44)) lsd_core_inst (.i_core_clk(clk), .i_nrst(nrst),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
        .i_halt_mode(halt), .o_backplane_active(bpl), .o_frame_even(even),
        .o_ground_all(gnd), .o_front_pixel(pix), .o_front_drive_en(den),
        .o_shared_com_sel(shsel), .o_shared_pin_data(shd), .o_en_switch(ensw),
        .o_hd_switch(hdsw), .o_contrast(con), .o_supply_external(ext), .o_sof(sof),
        .o_irq(irq));
    lsd_panel_model lsd_panel_model_inst (.i_core_clk(clk), .i_nrst(nrst),
        .i_frame_even(even), .i_ground_all(gnd), .o_frames(frames));
    // ========================================
    // Bus and check helpers
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        adr <= a;
        wd <= {24'h000000, d};
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask
    task automatic until_bpl(input logic [7:0] v);
        for (int n = 0; n < 300 && bpl !== v; n++) @(posedge clk);
    endtask
    task automatic odd_start();
        // Edge of even to odd gives a whole odd frame ahead
        for (int n = 0; n < 300 && even !== 1'b1; n++) @(posedge clk);
        for (int n = 0; n < 300 && even !== 1'b0; n++) @(posedge clk);
    endtask
    // ========================================
    // Scenarios
    task automatic t_regs();
        chk("ground", 1, gnd);
        xfer(0, LSD_IDX_CTRL2, 0);
        chk("ctrl2", 0, q);
        xfer(1, 6'h0b, 8'hff);
        xfer(0, 6'h0b, 0);
        chk("unmapped", 0, q);
        xfer(1, LSD_IDX_CTRL2, 8'h11);
        settle();
        chk("hold", 1, hdsw);
        chk("supply", 1, ext);
        xfer(1, LSD_IDX_CTRL2, 8'h00);
        settle();
        chk("hold off", 0, hdsw);
        chk("booster", 0, ext);
    endtask
    task automatic t_run();
        xfer(1, LSD_IDX_MASK0, 8'h01);
        xfer(1, LSD_IDX_CTRL1, 8'h06);
        xfer(1, LSD_IDX_CTRL3, 8'h60);
        settle();
        chk("odd first", 0, even);
        chk("en sw", 1, ensw);
        chk("pin0", 1, den[0]);
        chk("pin1", 0, den[1]);
        for (int n = 0; n < 300 && sof !== 1'b1; n++) @(posedge clk);
        chk("flag", 1, sof);
        chk("irq", 1, irq);
        xfer(1, LSD_IDX_CTRL3, 8'h48);
        settle();
        chk("flag clr", 0, sof);
        chk("irq off", 0, irq);
        xfer(1, LSD_IDX_CTRL4, 8'h01);
        settle();
        chk("com sel", 1, shsel);
        chk("top seg", 0, den[43]);
    endtask
    task automatic t_mem();
        logic a;
        int n;
        xfer(1, LSD_IDX_CTRL3, 8'h48);
        for (n = 0; n < 600 && sof !== 1'b1; n++) @(posedge clk);
        xfer(1, 6'h12, 8'h01);
        xfer(0, 6'h12, 0);
        chk("ram", 1, q);
        until_bpl(8'h01);
        chk("com0 pix", 0, pix[0]);
        until_bpl(8'h02);
        chk("com1 pix", 1, pix[0]);
        until_bpl(8'h20);
        chk("shared com", 4'h2, shd);
        xfer(1, LSD_IDX_CTRL1, 8'hce);
        until_bpl(8'h02);
        a = pix[0];
        until_bpl(8'h04);
        until_bpl(8'h02);
        chk("blink", 1, a ^ pix[0]);
        xfer(1, LSD_IDX_CTRL1, 8'h06);
        xfer(1, LSD_IDX_CTRL2, 8'h40);
        for (n = 0; n < 40 && hdsw !== 1'b1; n++) @(posedge clk);
        for (n = 0; n < 20 && hdsw === 1'b1; n++) @(posedge clk);
        chk("pulse", 2, n);
        xfer(1, LSD_IDX_CTRL2, 8'h00);
        xfer(1, LSD_IDX_CTRL3, 8'h43);
        for (n = 0; n < 400 && gnd !== 1'b1; n++) @(posedge clk);
        for (n = 0; n < 300 && gnd === 1'b1; n++) @(posedge clk);
        chk("dead", 48, n);
        chk("odd after dead", 0, even);
    endtask
    task automatic t_stop();
        odd_start();
        xfer(1, LSD_IDX_CTRL2, 8'h0a);
        xfer(1, LSD_IDX_CTRL3, 8'h00);
        settle();
        chk("contrast hold", 0, con);
        chk("en sw held", 1, ensw);
        chk("not grounded", 0, gnd);
        for (int n = 0; n < 400 && gnd !== 1'b1; n++) @(posedge clk);
        chk("grounded", 1, gnd);
        chk("en sw open", 0, ensw);
        chk("contrast", 5, con);
        xfer(1, LSD_IDX_CTRL3, 8'h40);
        repeat (40) @(posedge clk);
        halt <= 1'b1;
        settle();
        f0 = frames;
        chk("halt gnd", 1, gnd);
        repeat (200) @(posedge clk);
        chk("halt frames", f0, frames);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ========================================
    // Clock, reset, watchdog
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        // Whole run is a few thousand cycles; 50k is ample margin
        repeat (50000) @(posedge clk);
        miscompares++;
        complete_run();
    end
    initial
    begin
        {nrst, rd, wr, halt, adr, wd} <= '0;
        be <= 4'h1;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_run();
        t_mem();
        t_stop();
        complete_run();
    end
endmodule
`default_nettype wire
